// *** bvl_cap_regs.sv ***
// link capability, link status/control and device capability two registers of the virtual side
`timescale 1ns/1ps

module bvl_cap_regs (
  input wire logic clock, // core clock, 125 MHz
  input wire logic rst_n, // fundamental reset, active low
  input wire bvl_pkg::bvl_cfg_req_t cfgReq, // configuration request
  output bvl_pkg::bvl_cfg_rsp_t cfgRsp, // configuration answer
  input wire bvl_pkg::bvl_load_t loadReq, // eeprom or i2c load
  input wire logic [1:0] speedLimitStrap, // three-level speed strap pin
  input wire logic [5:0] bridgePortSelectStraps, // three straps, 2 bits each
  input wire logic [5:0] stationLaneConfigWidth, // one-hot width from lane config
  input wire logic [4:0] upstreamPortField, // management port field
  input wire logic upstreamPortFieldValid, // field has been programmed
  input wire logic linkUp, // link side is up
  input wire logic [3:0] linkSpeed, // negotiated speed index
  input wire logic [5:0] linkWidth, // negotiated one-hot width
  output logic l1EntryAllowed // permission to enter L1, held low
);

  // ************************************************************
  // helper functions
  // ************************************************************

  // dword address match, low address bits ignored
  function automatic logic offHit(input logic [11:0] addr, input logic [11:0] off);
    offHit = (addr[11:2] == off[11:2]);
  endfunction

  // index of the highest set bit of the vector field, vector bit n+1 at field bit n
  function automatic logic [3:0] topSpeed(input logic [6:0] vec);
    topSpeed = bvl_pkg::SPEED_NONE;
    for (int k = 0; k < 7; k++) begin
      if (vec[k]) begin
        topSpeed = 4'(k + 1);
      end
    end
  endfunction

  // legal one-hot lane count, x1 to x16
  function automatic logic legalWidth(input logic [5:0] w);
    legalWidth = (w != bvl_pkg::WIDTH_DOWN) && (w <= bvl_pkg::WIDTH_X16) && ((w & (w - 6'h01)) == 6'h00);
  endfunction

  // byte enables spread to a bit mask
  function automatic logic [31:0] beMask(input logic [3:0] be);
    beMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // strap code triple to port number, reserved codes give the fallback
  function automatic logic [7:0] strapPort(input logic [5:0] s);
    case (s)
      {bvl_pkg::TRI_LOW, bvl_pkg::TRI_LOW, bvl_pkg::TRI_LOW}: strapPort = 8'h00;
      {bvl_pkg::TRI_LOW, bvl_pkg::TRI_LOW, bvl_pkg::TRI_FLOAT}: strapPort = 8'h01;
      {bvl_pkg::TRI_LOW, bvl_pkg::TRI_LOW, bvl_pkg::TRI_HIGH}: strapPort = 8'h02;
      {bvl_pkg::TRI_LOW, bvl_pkg::TRI_FLOAT, bvl_pkg::TRI_LOW}: strapPort = 8'h03;
      {bvl_pkg::TRI_LOW, bvl_pkg::TRI_HIGH, bvl_pkg::TRI_HIGH}: strapPort = 8'h08;
      {bvl_pkg::TRI_FLOAT, bvl_pkg::TRI_LOW, bvl_pkg::TRI_LOW}: strapPort = 8'h09;
      {bvl_pkg::TRI_FLOAT, bvl_pkg::TRI_LOW, bvl_pkg::TRI_FLOAT}: strapPort = 8'h0a;
      {bvl_pkg::TRI_FLOAT, bvl_pkg::TRI_LOW, bvl_pkg::TRI_HIGH}: strapPort = 8'h0b;
      {bvl_pkg::TRI_FLOAT, bvl_pkg::TRI_HIGH, bvl_pkg::TRI_FLOAT}: strapPort = 8'h10;
      {bvl_pkg::TRI_FLOAT, bvl_pkg::TRI_HIGH, bvl_pkg::TRI_HIGH}: strapPort = 8'h11;
      {bvl_pkg::TRI_HIGH, bvl_pkg::TRI_LOW, bvl_pkg::TRI_LOW}: strapPort = 8'h12;
      {bvl_pkg::TRI_HIGH, bvl_pkg::TRI_LOW, bvl_pkg::TRI_FLOAT}: strapPort = 8'h13;
      default: strapPort = bvl_pkg::PORT_RSVD;
    endcase
  endfunction

  // port numbers that the mapping can produce
  function automatic logic legalPort(input logic [4:0] p);
    legalPort = (p[4:2] == 3'h0) || (p[4:2] == 3'h2) || (p[4:2] == 3'h4);
  endfunction

  // ************************************************************
  // strap synchronisation and capture
  // ************************************************************
  logic [bvl_pkg::STRAP_W-1:0] strapSync; // straps in the clock domain
  bvl_pkg::bvl_cap_state_t capState_reg; // capture sequence state
  bvl_pkg::bvl_cap_state_t capState_next; // next capture state
  logic [1:0] settleCnt_reg; // cycles since reset release
  logic [1:0] speedStrap_reg; // captured speed strap code
  logic [5:0] portStrap_reg; // captured port select codes

  bvl_strap_sync #(
    .WIDTH(bvl_pkg::STRAP_W)
  ) strapSyncInst (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn({speedLimitStrap, bridgePortSelectStraps}),
    .syncOut(strapSync)
  );

  // straps are sampled once after the chain has filled, so a pin that bounces later changes nothing
  always_comb begin
    capState_next = capState_reg;
    case (capState_reg)
      bvl_pkg::CAP_SETTLE: begin
        if (settleCnt_reg == bvl_pkg::SETTLE_CYCLES) begin
          capState_next = bvl_pkg::CAP_TAKE;
        end
      end
      bvl_pkg::CAP_TAKE: begin
        capState_next = bvl_pkg::CAP_HOLD;
      end
      bvl_pkg::CAP_HOLD: begin
        capState_next = bvl_pkg::CAP_HOLD;
      end
      default: begin
        capState_next = bvl_pkg::CAP_SETTLE;
      end
    endcase
  end

  // capture state and settle counter
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capState_reg <= bvl_pkg::CAP_SETTLE;
      settleCnt_reg <= 2'h0;
    end else begin
      capState_reg <= capState_next;
      settleCnt_reg <= (capState_reg == bvl_pkg::CAP_SETTLE) ? settleCnt_reg + 2'h1 : settleCnt_reg;
    end
  end

  // strap values, full speed until captured
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      speedStrap_reg <= bvl_pkg::TRI_HIGH;
      portStrap_reg <= 6'h00;
    end else if (capState_reg == bvl_pkg::CAP_TAKE) begin
      speedStrap_reg <= strapSync[7:6];
      portStrap_reg <= strapSync[5:0];
    end
  end

  // ************************************************************
  // access decode
  // ************************************************************
  wire cfgWr = cfgReq.valid && cfgReq.write; // write strobe
  wire wrCtl = cfgWr && offHit(cfgReq.addr, bvl_pkg::OFF_LINK_STS_CTL); // link control write
  wire ldCap = loadReq.valid && offHit(loadReq.addr, bvl_pkg::OFF_LINK_CAP); // capability load
  wire ldCtl = loadReq.valid && offHit(loadReq.addr, bvl_pkg::OFF_LINK_STS_CTL); // control load
  wire ldCap2 = loadReq.valid && offHit(loadReq.addr, bvl_pkg::OFF_DEV_CAP2); // atomic load
  wire ldVec = loadReq.valid && offHit(loadReq.addr, bvl_pkg::OFF_LINK_CAP2); // vector load
  wire cfgHit = offHit(cfgReq.addr, bvl_pkg::OFF_DEV_STS_CTL)
             || offHit(cfgReq.addr, bvl_pkg::OFF_LINK_CAP)
             || offHit(cfgReq.addr, bvl_pkg::OFF_LINK_STS_CTL)
             || offHit(cfgReq.addr, bvl_pkg::OFF_DEV_CAP2)
             || offHit(cfgReq.addr, bvl_pkg::OFF_DEV_STS_CTL2)
             || offHit(cfgReq.addr, bvl_pkg::OFF_LINK_CAP2); // mapped here

  // loaded dword seen through each layout
  bvl_pkg::bvl_link_cap_t ldCapV; // capability layout
  bvl_pkg::bvl_link_sc_t ldCtlV; // control layout
  bvl_pkg::bvl_dev_cap2_t ldCap2V; // atomic layout
  bvl_pkg::bvl_link_cap2_t ldVecV; // vector layout
  assign ldCapV = bvl_pkg::bvl_link_cap_t'(loadReq.data);
  assign ldCtlV = bvl_pkg::bvl_link_sc_t'(loadReq.data);
  assign ldCap2V = bvl_pkg::bvl_dev_cap2_t'(loadReq.data);
  assign ldVecV = bvl_pkg::bvl_link_cap2_t'(loadReq.data);

  // ************************************************************
  // capability state
  // ************************************************************
  logic [6:0] supVec_reg; // supported speeds vector
  logic [1:0] aspmSup_reg; // aspm support code
  logic [2:0] l1Lat_reg; // L1 exit latency code
  logic clkPm_reg; // clock power management
  logic aspmOpt_reg; // aspm optionality
  logic [5:0] maxWidth_reg; // maximum width
  logic [7:0] portNum_reg; // port number
  logic [2:0] atomic_reg; // atomic completer bits

  // the strap trims the vector before its top bit is taken, so every port drops together
  wire [6:0] speedMask = (speedStrap_reg == bvl_pkg::TRI_LOW) ? bvl_pkg::SUP_MASK_GEN1 :
                         (speedStrap_reg == bvl_pkg::TRI_FLOAT) ? bvl_pkg::SUP_MASK_GEN2 :
                         bvl_pkg::SUP_MASK_ALL;
  wire [3:0] maxSpeed = topSpeed(supVec_reg & speedMask);

  // loadable capability fields; reserved aspm codes in a load are dropped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      supVec_reg <= bvl_pkg::SUP_VEC_RST;
      aspmSup_reg <= bvl_pkg::ASPM_L0S;
      l1Lat_reg <= bvl_pkg::L1_LAT_RST;
      clkPm_reg <= 1'b0;
      aspmOpt_reg <= bvl_pkg::ASPM_OPT_RST;
      atomic_reg <= bvl_pkg::ATOMIC_RST;
    end else begin
      supVec_reg <= ldVec ? ldVecV.supVec : supVec_reg;
      if (ldCap && (ldCapV.aspmSup == bvl_pkg::ASPM_L0S || ldCapV.aspmSup == bvl_pkg::ASPM_L0S_L1)) begin
        aspmSup_reg <= ldCapV.aspmSup;
      end
      l1Lat_reg <= ldCap ? ldCapV.l1Lat : l1Lat_reg;
      clkPm_reg <= ldCap ? ldCapV.clkPm : clkPm_reg;
      aspmOpt_reg <= ldCap ? ldCapV.aspmOpt : aspmOpt_reg;
      atomic_reg <= ldCap2 ? ldCap2V.atomic : atomic_reg;
    end
  end

  // width follows lane configuration; an illegal code keeps the last good one
  // port number: a programmed legal field wins over the strap decode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      maxWidth_reg <= bvl_pkg::WIDTH_X16;
      portNum_reg <= bvl_pkg::PORT_RSVD;
    end else begin
      maxWidth_reg <= legalWidth(stationLaneConfigWidth) ? stationLaneConfigWidth : maxWidth_reg;
      if (upstreamPortFieldValid && legalPort(upstreamPortField)) begin
        portNum_reg <= {3'h0, upstreamPortField};
      end else begin
        portNum_reg <= strapPort(portStrap_reg);
      end
    end
  end

  // ************************************************************
  // link control and status
  // ************************************************************
  logic [1:0] aspmCtl_reg; // aspm control, stored only
  logic commonClk_reg; // common clock, stored only
  logic extSync_reg; // extended sync, stored only
  logic rcb_reg; // read completion boundary
  logic [3:0] curSpeed_reg; // current speed
  logic [5:0] negWidth_reg; // negotiated width

  bvl_pkg::bvl_link_sc_t ctlView; // control register as read
  bvl_pkg::bvl_link_sc_t ctlMerged; // control after byte-enable merge
  assign ctlMerged = bvl_pkg::bvl_link_sc_t'((ctlView & ~beMask(cfgReq.byteEn)) | (cfgReq.wdata & beMask(cfgReq.byteEn)));

  // these bits steer nothing: no outside link exists behind the virtual side
  // a host write in the same cycle as a load wins, being the later intent
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aspmCtl_reg <= 2'h0;
      commonClk_reg <= 1'b0;
      extSync_reg <= 1'b0;
      rcb_reg <= 1'b0;
    end else begin
      if (wrCtl) begin
        aspmCtl_reg <= ctlMerged.aspmCtl;
        commonClk_reg <= ctlMerged.commonClk;
        extSync_reg <= ctlMerged.extSync;
      end else if (ldCtl) begin
        aspmCtl_reg <= ldCtlV.aspmCtl;
        commonClk_reg <= ldCtlV.commonClk;
        extSync_reg <= ldCtlV.extSync;
      end
      rcb_reg <= ldCtl ? ldCtlV.rcb : rcb_reg;
    end
  end

  // status mirrors the link side; speed holds its last value while down, width shows zero
  wire speedOk = (linkSpeed != bvl_pkg::SPEED_NONE) && (linkSpeed <= maxSpeed); // usable index
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      curSpeed_reg <= bvl_pkg::CUR_SPEED_RST;
      negWidth_reg <= bvl_pkg::WIDTH_DOWN;
    end else begin
      curSpeed_reg <= (linkUp && speedOk) ? linkSpeed : curSpeed_reg;
      if (!linkUp) begin
        negWidth_reg <= bvl_pkg::WIDTH_DOWN;
      end else if (legalWidth(linkWidth)) begin
        negWidth_reg <= linkWidth;
      end
    end
  end

  // ************************************************************
  // read views; every field not assigned stays zero
  // ************************************************************
  bvl_pkg::bvl_link_cap_t capView; // link capability
  bvl_pkg::bvl_dev_cap2_t cap2View; // device capability two
  bvl_pkg::bvl_link_cap2_t vecView; // supported vector

  always_comb begin
    capView = '0;
    capView.maxSpeed = maxSpeed;
    capView.maxWidth = maxWidth_reg;
    capView.aspmSup = aspmSup_reg;
    capView.l0sLat = bvl_pkg::L0S_LAT;
    capView.l1Lat = l1Lat_reg;
    capView.clkPm = clkPm_reg;
    capView.aspmOpt = aspmOpt_reg;
    capView.portNum = portNum_reg;
  end

  // training, disable, retrain and slot clock never leave zero
  always_comb begin
    ctlView = '0;
    ctlView.aspmCtl = aspmCtl_reg;
    ctlView.rcb = rcb_reg;
    ctlView.commonClk = commonClk_reg;
    ctlView.extSync = extSync_reg;
    ctlView.curSpeed = curSpeed_reg;
    ctlView.negWidth = negWidth_reg;
  end

  always_comb begin
    cap2View = '0;
    cap2View.atomic = atomic_reg;
    vecView = '0;
    vecView.supVec = supVec_reg;
  end

  // read selection; status tail and control two are all zero here
  logic [31:0] readData; // selected dword
  always_comb begin
    if (offHit(cfgReq.addr, bvl_pkg::OFF_LINK_CAP)) begin
      readData = capView;
    end else if (offHit(cfgReq.addr, bvl_pkg::OFF_LINK_STS_CTL)) begin
      readData = ctlView;
    end else if (offHit(cfgReq.addr, bvl_pkg::OFF_DEV_CAP2)) begin
      readData = cap2View;
    end else if (offHit(cfgReq.addr, bvl_pkg::OFF_LINK_CAP2)) begin
      readData = vecView;
    end else begin
      readData = 32'h0000_0000;
    end
  end

  // ************************************************************
  // answer and outputs
  // ************************************************************
  bvl_pkg::bvl_cfg_rsp_t rsp_reg; // registered answer
  logic l1Allow_reg; // L1 permission

  // one answer per request, one cycle later; writes answer with zero data
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_reg <= '0;
      l1Allow_reg <= 1'b0;
    end else begin
      rsp_reg.ack <= cfgReq.valid;
      rsp_reg.hit <= cfgReq.valid && cfgHit;
      rsp_reg.rdata <= (cfgReq.valid && !cfgReq.write) ? readData : 32'h0000_0000;
      l1Allow_reg <= 1'b0;
    end
  end

  assign cfgRsp = rsp_reg;
  assign l1EntryAllowed = l1Allow_reg;

endmodule

// *** bvl_pkg.sv ***
// shared constants, register layouts and carrier types for the link capability bank
package bvl_pkg;

  // ************************************************************
  // register offsets (byte addresses of dword registers)
  // ************************************************************
  localparam logic [11:0] OFF_DEV_STS_CTL = 12'h070; // device status tail
  localparam logic [11:0] OFF_LINK_CAP = 12'h074; // link capability
  localparam logic [11:0] OFF_LINK_STS_CTL = 12'h078; // link status and control
  localparam logic [11:0] OFF_DEV_CAP2 = 12'h08c; // device capability two
  localparam logic [11:0] OFF_DEV_STS_CTL2 = 12'h090; // device status and control two
  localparam logic [11:0] OFF_LINK_CAP2 = 12'h094; // supported speeds vector

  // ************************************************************
  // reset values and codes
  // ************************************************************
  localparam logic [3:0] SPEED_GEN1 = 4'h1; // 2.5 GT/s index
  localparam logic [3:0] SPEED_NONE = 4'h0; // no speed supported
  localparam logic [6:0] SUP_VEC_RST = 7'h07; // 2.5, 5.0 and 8.0 GT/s
  localparam logic [6:0] SUP_MASK_GEN1 = 7'h01; // keep 2.5 GT/s only
  localparam logic [6:0] SUP_MASK_GEN2 = 7'h03; // keep up to 5.0 GT/s
  localparam logic [6:0] SUP_MASK_ALL = 7'h7f; // no strap limit
  localparam logic [1:0] ASPM_L0S = 2'h1; // L0s only
  localparam logic [1:0] ASPM_L0S_L1 = 2'h3; // L0s and L1
  localparam logic [2:0] L0S_LAT = 3'h6; // two to four microseconds
  localparam logic [2:0] L1_LAT_RST = 3'h2; // two to four microseconds
  localparam logic ASPM_OPT_RST = 1'h1; // optionality compliant
  localparam logic [3:0] CUR_SPEED_RST = 4'h1; // 2.5 GT/s
  localparam logic [5:0] WIDTH_DOWN = 6'h00; // link down
  localparam logic [5:0] WIDTH_X16 = 6'h10; // widest legal code
  localparam logic [2:0] ATOMIC_RST = 3'h7; // 32, 64 and 128 bit completer
  localparam logic [7:0] PORT_RSVD = 8'h00; // answer for a reserved strap code

  // ************************************************************
  // three-level strap codes and capture timing
  // ************************************************************
  localparam logic [1:0] TRI_LOW = 2'h0; // strap tied low
  localparam logic [1:0] TRI_HIGH = 2'h1; // strap tied high
  localparam logic [1:0] TRI_FLOAT = 2'h2; // strap left open
  localparam int STRAP_W = 8; // speed strap plus three port straps
  localparam logic [1:0] SETTLE_CYCLES = 2'h2; // synchroniser depth

  // strap capture sequence after reset release
  typedef enum logic [2:0] {
    CAP_SETTLE = 3'b001,
    CAP_TAKE = 3'b010,
    CAP_HOLD = 3'b100
  } bvl_cap_state_t;

  // ************************************************************
  // register layouts, msb first
  // ************************************************************
  typedef struct packed {
    logic [7:0] portNum; // isolating bridge port number
    logic rsvd23; // reserved
    logic aspmOpt; // aspm optionality compliance
    logic [2:0] rsvd21; // reserved
    logic clkPm; // clock power management
    logic [2:0] l1Lat; // L1 exit latency code
    logic [2:0] l0sLat; // L0s exit latency code
    logic [1:0] aspmSup; // aspm support
    logic [5:0] maxWidth; // one-hot lane count
    logic [3:0] maxSpeed; // speed vector index
  } bvl_link_cap_t;

  typedef struct packed {
    logic [2:0] rsvd29; // reserved
    logic slotClk; // slot clock configuration
    logic training; // link training
    logic rsvd26; // reserved
    logic [5:0] negWidth; // negotiated width
    logic [3:0] curSpeed; // current speed
    logic [7:0] rsvd8; // reserved
    logic extSync; // extended sync
    logic commonClk; // common clock configuration
    logic retrain; // retrain link
    logic disable_; // link disable
    logic rcb; // read completion boundary
    logic rsvd2; // reserved
    logic [1:0] aspmCtl; // aspm control
  } bvl_link_sc_t;

  typedef struct packed {
    logic [21:0] rsvd10; // reserved
    logic [2:0] atomic; // 128, 64, 32 bit completer
    logic [6:0] rsvd0; // reserved
  } bvl_dev_cap2_t;

  typedef struct packed {
    logic [23:0] rsvd8; // reserved
    logic [6:0] supVec; // supported speeds vector
    logic rsvd0; // reserved
  } bvl_link_cap2_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic valid; // request strobe, one cycle
    logic write; // 1 write, 0 read
    logic [11:0] addr; // byte address
    logic [3:0] byteEn; // write byte enables
    logic [31:0] wdata; // write data
  } bvl_cfg_req_t;

  typedef struct packed {
    logic ack; // answer strobe, one cycle
    logic hit; // address is mapped here
    logic [31:0] rdata; // read data
  } bvl_cfg_rsp_t;

  typedef struct packed {
    logic valid; // load strobe
    logic [11:0] addr; // byte address
    logic [31:0] data; // loaded dword
  } bvl_load_t;

endpackage

// *** bvl_strap_sync.sv ***
// two-flop synchroniser for strap pins
`timescale 1ns/1ps
module bvl_strap_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [WIDTH-1:0] asyncIn, // raw pin levels
  output logic [WIDTH-1:0] syncOut // levels in the clock domain
);

  // ************************************************************
  // one two-stage chain per pin
  // ************************************************************
  logic [WIDTH-1:0] stage1_reg; // first stage, read only by stage two

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gSync
      // first stage may go metastable; nothing but stage two looks at it
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          stage1_reg[i] <= 1'b0;
          syncOut[i] <= 1'b0;
        end else begin
          stage1_reg[i] <= asyncIn[i];
          syncOut[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

endmodule

// *** bvl_cap_regs_props.sv ***
// concurrent checks on the configuration port and the L1 permission output of the link bank
`timescale 1ns/1ps
module bvl_cap_regs_props (
  input wire logic clock, // core clock
  input wire logic rst_n, // reset, active low
  input wire bvl_pkg::bvl_cfg_req_t cfgReq, // request
  input wire bvl_pkg::bvl_cfg_rsp_t cfgRsp, // answer
  input wire logic l1EntryAllowed // L1 permission
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire rdReq = cfgReq.valid && !cfgReq.write; // a read is taken
  wire [9:0] dw = cfgReq.addr[11:2]; // dword index, low bits ignored
  wire [31:0] rdat = cfgRsp.rdata; // answer data
  a_ack_follows: assert property (cfgReq.valid |=> cfgRsp.ack) else $error("request not answered");
  a_ack_single: assert property (!cfgReq.valid |=> !cfgRsp.ack) else $error("answer without request");
  a_no_l1: assert property (!l1EntryAllowed) else $error("L1 entry allowed");
  a_miss_zero: assert property (cfgRsp.ack && !cfgRsp.hit |-> rdat == 32'h0)
    else $error("unmapped data not zero");
  a_write_zero: assert property (cfgReq.valid && cfgReq.write |=> rdat == 32'h0)
    else $error("write answer carries data");
  a_pend_zero: assert property (rdReq && dw == 10'h01c |=> rdat[21] == 1'b0)
    else $error("pending bit set");
  a_l0s_fixed: assert property (rdReq && dw == 10'h01d |=> rdat[14:12] == 3'h6)
    else $error("L0s latency wrong");
  a_speed_legal: assert property (rdReq && dw == 10'h01d |=> rdat[3:0] inside {4'h1, 4'h2, 4'h3})
    else $error("max speed out of vector");
  a_status_zero: assert property (rdReq && dw == 10'h01e |=> rdat[31:26] == 6'h0 && rdat[5:4] == 2'h0)
    else $error("reserved status set");
  a_cap2_rsvd: assert property (rdReq && dw == 10'h023 |=> rdat[31:10] == 22'h0 && rdat[6:0] == 7'h0)
    else $error("reserved cap2 set");
  c_miss: cover property (cfgRsp.ack && !cfgRsp.hit);
  c_ctl_write: cover property (cfgReq.valid && cfgReq.write && dw == 10'h01e);
  c_cap_read: cover property (rdReq && dw == 10'h01d);
endmodule

// *** bvl_host_model.sv ***
// virtual side host issuing one dword configuration request at a time
`timescale 1ns/1ps
module bvl_host_model (
  input wire logic clock, // core clock
  output bvl_pkg::bvl_cfg_req_t cfgReq, // request to the bank
  input wire bvl_pkg::bvl_cfg_rsp_t cfgRsp // answer from the bank
);
  initial cfgReq = '0; // idle until the first request
  // answer is read once the taking edge has landed; stale write data is inverted
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [32:0] rsp);
    @(posedge clock);
    #1 cfgReq = '{valid: 1'b1, write: wr, addr: a, byteEn: 4'hf, wdata: d};
    @(posedge clock);
    #1 rsp = {cfgRsp.ack & cfgRsp.hit, cfgRsp.rdata};
    cfgReq.valid = 1'b0;
    cfgReq.wdata = ~d;
  endtask
endmodule

// *** tb_top.sv ***
// self-checking testbench for the link capability bank
`timescale 1ns/1ps
module tb_top;
  logic clock, rst_n; // core clock and reset
  bvl_pkg::bvl_cfg_req_t cfgReq; // host request
  bvl_pkg::bvl_cfg_rsp_t cfgRsp; // bank answer
  bvl_pkg::bvl_load_t loadReq; // eeprom load
  logic [1:0] speedStrap; // speed limit strap
  logic [5:0] portStraps; // bridge port select straps
  logic [4:0] portField; // management port field
  logic portFieldValid; // field programmed
  logic linkUp; // link side up
  logic [3:0] linkSpeed; // negotiated speed
  logic [5:0] linkWidth; // negotiated width
  logic [5:0] laneWidth; // lane configuration width
  logic l1Allowed; // L1 permission from the bank
  logic [32:0] rsp; // hit and data of last answer
  int fail_count = 0;
  int cmp_count = 0;
  bvl_host_model host(.clock, .cfgReq, .cfgRsp);
  bvl_cap_regs dut(.clock, .rst_n, .cfgReq, .cfgRsp, .loadReq, .speedLimitStrap(speedStrap),
    .bridgePortSelectStraps(portStraps), .stationLaneConfigWidth(laneWidth), .upstreamPortField(portField),
    .upstreamPortFieldValid(portFieldValid), .linkUp, .linkSpeed, .linkWidth, .l1EntryAllowed(l1Allowed));
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, rsp);
    chk(rsp, {1'b1, e});
  endtask
  task automatic load(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    #1 loadReq = '{valid: 1'b1, addr: a, data: d};
    @(posedge clock);
    #1 loadReq.valid = 1'b0;
  endtask
  // straps settle five edges after release, so wait six
  task automatic do_reset;
    rst_n = 0;
    repeat (10) @(posedge clock);
    #1 rst_n = 1;
    repeat (6) @(posedge clock);
  endtask
  task automatic t_reset_vals;
    rd(12'h074, 32'h0041_6503);
    rd(12'h078, 32'h0001_0000);
    rd(12'h08c, 32'h0000_0380);
    rd(12'h094, 32'h0000_000e);
    rd(12'h070, 32'h0000_0000);
    host.xfer(1'b0, 12'h0a0, 32'h0, rsp);
    chk(rsp, 33'h0);
    chk({32'h0, l1Allowed}, 33'h0);
  endtask
  // all ones written: only the three control fields may stick; writes answer hit with zero data
  task automatic t_ctl_write;
    host.xfer(1'b1, 12'h078, 32'hffff_ffff, rsp);
    chk(rsp, {1'b1, 32'h0});
    host.xfer(1'b1, 12'h074, 32'hffff_ffff, rsp);
    chk(rsp, {1'b1, 32'h0});
    rd(12'h078, 32'h0001_00c3);
    rd(12'h074, 32'h0041_6503);
  endtask
  task automatic t_link;
    linkUp = 1;
    linkSpeed = 4'h2;
    linkWidth = 6'h04;
    rd(12'h078, 32'h0042_00c3);
    linkUp = 0;
    rd(12'h078, 32'h0002_00c3);
  endtask
  // loaded vector lowers max speed; L0s latency code stays fixed; an illegal lane code keeps the last width
  task automatic t_load;
    laneWidth = 6'h08;
    load(12'h094, 32'h0000_0002);
    load(12'h074, 32'h0000_0c00);
    load(12'h08c, 32'h0000_0000);
    load(12'h078, 32'h0000_0008);
    rd(12'h074, 32'h0000_6c81);
    rd(12'h08c, 32'h0000_0000);
    rd(12'h078, 32'h0002_0008);
    laneWidth = 6'h03;
    rd(12'h074, 32'h0000_6c81);
    laneWidth = 6'h10;
  endtask
  task automatic t_straps;
    portStraps = 6'h26;
    for (int i = 0; i < 2; i++) begin
      speedStrap = i ? bvl_pkg::TRI_FLOAT : bvl_pkg::TRI_LOW;
      do_reset();
      rd(12'h074, 32'h1041_6501 + i);
    end
    portFieldValid = 1;
    portField = 5'h09;
    rd(12'h074, 32'h0941_6502);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #40000;
    fail_count++;
    results();
  end
  initial begin
    loadReq = '0;
    speedStrap = bvl_pkg::TRI_HIGH;
    portStraps = 6'h00;
    portField = 5'h00;
    portFieldValid = 0;
    linkUp = 0;
    linkSpeed = 4'h0;
    linkWidth = 6'h00;
    laneWidth = 6'h10;
    do_reset();
    t_reset_vals();
    t_ctl_write();
    t_link();
    t_load();
    t_straps();
    results();
  end
endmodule
bind bvl_cap_regs bvl_cap_regs_props chk(.clock, .rst_n, .cfgReq, .cfgRsp, .l1EntryAllowed);
